// ==== shared/flash_status_pkg.sv ====
package flash_status_pkg;

  // Clock rate and bus timing for the asynchronous flash read and write cycles
  localparam int unsigned clk_mhz = 100;
  localparam int unsigned read_low_ns = 70;
  localparam int unsigned read_low_cycles = (read_low_ns * clk_mhz + 999) / 1000;
  localparam int unsigned write_low_ns = 50;
  localparam int unsigned write_low_cycles = (write_low_ns * clk_mhz + 999) / 1000;
  localparam int unsigned gap_ns = 30;
  localparam int unsigned gap_cycles = (gap_ns * clk_mhz + 999) / 1000;
  localparam int unsigned count_w = 8;

  // Status bit positions on the data bus
  localparam int unsigned polling_bit_pos = 7;
  localparam int unsigned first_toggle_bit_pos = 6;
  localparam int unsigned timeout_flag_pos = 5;
  localparam int unsigned erase_timer_flag_pos = 3;
  localparam int unsigned second_toggle_bit_pos = 2;

  // Flash reset command byte
  localparam logic [7:0] reset_cmd = 8'hf0;

  // Controller register offsets (word addresses)
  localparam logic [3:0] ctrl_off = 4'h0;
  localparam logic [3:0] addr_off = 4'h1;
  localparam logic [3:0] data_off = 4'h2;
  localparam logic [3:0] stat_off = 4'h3;
  localparam logic [3:0] last_off = 4'h4;

  // Control register bits
  localparam int unsigned go_toggle_pos = 0;
  localparam int unsigned go_poll_pos = 1;
  localparam int unsigned go_read_pos = 2;
  localparam int unsigned go_write_pos = 3;
  localparam int unsigned abort_pos = 4;

  // Status register bits
  localparam int unsigned st_busy_pos = 0;
  localparam int unsigned st_done_pos = 1;
  localparam int unsigned st_fail_pos = 2;
  localparam int unsigned st_rdy_pos = 3;

  localparam logic [20:0] addr_reset = 21'h000000;
  localparam logic [7:0] data_reset = 8'h00;

  // One flash bus cycle request and its answer
  typedef struct packed {
    logic go;
    logic write;
    logic [20:0] addr;
    logic [7:0] data;
  } bus_req_s;

  typedef struct packed {
    logic done;
    logic [7:0] data;
  } bus_ans_s;

  // Flash pins driven by the controller
  typedef struct packed {
    logic chip_select_n;
    logic output_strobe_n;
    logic write_strobe_n;
    logic [20:0] addr;
    logic [7:0] dq_out;
    logic dq_oe;
  } flash_pins_s;

endpackage : flash_status_pkg

// ==== hdl/flash_bus_cycle.sv ====
module flash_bus_cycle (
  input wire logic ref_clk, // 100 MHz clock
  input wire logic reset, // Async reset, active high
  input flash_status_pkg::bus_req_s req, // Cycle request
  output flash_status_pkg::bus_ans_s ans, // Cycle answer
  output flash_status_pkg::flash_pins_s pins, // Flash pins
  input wire logic [7:0] dq_in // Data pins, synchronised
);

  typedef enum logic [3:0] {
    st_idle = 4'b0001,
    st_low = 4'b0010,
    st_gap = 4'b0100,
    st_done = 4'b1000
  } cyc_e;

  typedef struct packed {
    cyc_e st;
    logic [flash_status_pkg::count_w-1:0] cnt;
    logic write;
    logic [7:0] data;
    flash_status_pkg::flash_pins_s pins;
  } cyc_s;

  cyc_s s_reg;
  cyc_s s_next;

  function automatic logic [flash_status_pkg::count_w-1:0] cyc_len(input int unsigned n);
    cyc_len = flash_status_pkg::count_w'(n);
  endfunction : cyc_len

  ////////////////////////////////////////////////////////////////////
  // One strobe pulse per request; strobes both rise so the flash sees edges
  always_comb begin
    s_next = s_reg;
    unique case (s_reg.st)
      st_idle: begin
        if (req.go) begin
          s_next.st = st_low;
          s_next.write = req.write;
          s_next.pins.addr = req.addr;
          s_next.pins.chip_select_n = 1'b0;
          s_next.pins.dq_out = req.data;
          s_next.pins.dq_oe = req.write;
          s_next.pins.write_strobe_n = ~req.write;
          s_next.pins.output_strobe_n = req.write;
          s_next.cnt = req.write ? cyc_len(flash_status_pkg::write_low_cycles)
                                 : cyc_len(flash_status_pkg::read_low_cycles);
        end
      end
      st_low: begin
        if (s_reg.cnt > 1) begin
          s_next.cnt = s_reg.cnt - 1'b1;
        end else begin
          // Latch data before the strobe rises, one read cycle ends here
          s_next.data = dq_in;
          s_next.pins.write_strobe_n = 1'b1;
          s_next.pins.output_strobe_n = 1'b1;
          s_next.pins.chip_select_n = 1'b1;
          s_next.st = st_gap;
          s_next.cnt = cyc_len(flash_status_pkg::gap_cycles);
        end
      end
      st_gap: begin
        // Hold data a while after the write strobe rises
        if (s_reg.cnt > 1) begin
          s_next.cnt = s_reg.cnt - 1'b1;
        end else begin
          s_next.pins.dq_oe = 1'b0;
          s_next.st = st_done;
        end
      end
      st_done: begin
        s_next.st = st_idle;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s_reg.st <= st_idle;
      s_reg.cnt <= '0;
      s_reg.write <= 1'b0;
      s_reg.data <= flash_status_pkg::data_reset;
      s_reg.pins <= '{chip_select_n: 1'b1, output_strobe_n: 1'b1, write_strobe_n: 1'b1,
                      addr: flash_status_pkg::addr_reset, dq_out: 8'h00, dq_oe: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign pins = s_reg.pins;
  assign ans.done = (s_reg.st == st_done);
  assign ans.data = s_reg.data;

endmodule : flash_bus_cycle

// ==== hdl/flash_status_host.sv ====
// Notes on behaviour
// - Status reads for polling go to the programmed address.
// - Sector erase status is read inside a chosen sector.
// - After polling bit turns true, full byte is taken on a later read.
// - Toggle test reads full byte twice and compares bit 6 only; equal means finished.
// - Toggling with timeout set: recheck, then issue reset command if still toggling.
// - Monitoring paused restarts the toggle check from its first step.
// - Polling bit is read again even after timeout flag is seen set; here the re-read is judged on bit 6 toggling, not bit 7.
// - Chip erase polling uses any non-protected sector address.
//
// Decided for this implementation: strobed register access and the address map.
module flash_status_host (
  input wire logic ref_clk, // 100 MHz clock
  input wire logic reset, // Async reset, active high
  input wire logic [3:0] reg_addr, // Register word address
  input wire logic [31:0] reg_wdata, // Register write data
  input wire logic reg_write, // Write strobe
  input wire logic reg_read, // Read strobe
  output logic [31:0] reg_rdata, // Read data, cycle after strobe
  output logic [20:0] flash_addr, // Flash address pins
  input wire logic [7:0] flash_dq_in, // Flash data pins in
  output logic [7:0] flash_dq_out, // Flash data pins out
  output logic flash_dq_oe, // High while driving data pins
  output logic chip_select_n, // Flash chip select
  output logic output_strobe_n, // Flash read strobe
  output logic write_strobe_n, // Flash write strobe
  input wire logic ready_busy_n // Flash open-drain ready line
);

  typedef enum logic [7:0] {
    h_idle = 8'b00000001,
    h_rd1 = 8'b00000010,
    h_rd2 = 8'b00000100,
    h_rd3 = 8'b00001000,
    h_rd4 = 8'b00010000,
    h_poll = 8'b00100000,
    h_rst = 8'b01000000,
    h_one = 8'b10000000
  } host_e;

  typedef struct packed {
    host_e st;
    logic [20:0] addr;
    logic [7:0] wdata;
    logic [7:0] expect_data;
    logic [7:0] first;
    logic [7:0] last;
    logic done;
    logic fail;
    logic [31:0] rdata;
    logic [7:0] dq_s1;
    logic [7:0] dq_s2;
    logic rb_s1;
    logic rb_s2;
    flash_status_pkg::bus_req_s req;
  } host_s;

  host_s s_reg;
  host_s s_next;
  flash_status_pkg::bus_ans_s ans;
  flash_status_pkg::flash_pins_s pins;

  // First toggle bit (bit 6) differs between two reads
  function automatic logic toggling(input logic [7:0] a, input logic [7:0] b);
    toggling = (a[flash_status_pkg::first_toggle_bit_pos] !=
                b[flash_status_pkg::first_toggle_bit_pos]);
  endfunction : toggling

  function automatic flash_status_pkg::bus_req_s rd_req(input logic [20:0] a);
    rd_req = '{go: 1'b1, write: 1'b0, addr: a, data: 8'h00};
  endfunction : rd_req

  ////////////////////////////////////////////////////////////////////
  // Bus cycle engine on the flash pins
  flash_bus_cycle u_cycle (
    .ref_clk(ref_clk),
    .reset(reset),
    .req(s_reg.req),
    .ans(ans),
    .pins(pins),
    .dq_in(s_reg.dq_s2)
  );

  ////////////////////////////////////////////////////////////////////
  // Register access and status procedures
  always_comb begin
    s_next = s_reg;
    s_next.req.go = 1'b0;
    // Pins come from outside, two flops before use
    s_next.dq_s1 = flash_dq_in;
    s_next.dq_s2 = s_reg.dq_s1;
    s_next.rb_s1 = ready_busy_n;
    s_next.rb_s2 = s_reg.rb_s1;
    // Read data stands only in the cycle after the strobe
    s_next.rdata = 32'h00000000;
    if (reg_read) begin
      unique case (reg_addr)
        flash_status_pkg::addr_off: s_next.rdata = {11'h000, s_reg.addr};
        flash_status_pkg::data_off: s_next.rdata = {16'h0000, s_reg.expect_data, s_reg.wdata};
        flash_status_pkg::stat_off: begin
          s_next.rdata[flash_status_pkg::st_busy_pos] = (s_reg.st != h_idle);
          s_next.rdata[flash_status_pkg::st_done_pos] = s_reg.done;
          s_next.rdata[flash_status_pkg::st_fail_pos] = s_reg.fail;
          s_next.rdata[flash_status_pkg::st_rdy_pos] = s_reg.rb_s2;
        end
        flash_status_pkg::last_off: s_next.rdata = {24'h000000, s_reg.last};
        default: s_next.rdata = 32'h00000000;
      endcase
    end
    if (reg_write && reg_addr == flash_status_pkg::addr_off) begin
      s_next.addr = reg_wdata[20:0];
    end
    if (reg_write && reg_addr == flash_status_pkg::data_off) begin
      s_next.wdata = reg_wdata[7:0];
      s_next.expect_data = reg_wdata[15:8];
    end
    // Abort leaves the procedure; a later start begins from the top
    if (reg_write && reg_addr == flash_status_pkg::ctrl_off &&
        reg_wdata[flash_status_pkg::abort_pos]) begin
      // A bus cycle may still be in flight; drain it so a restart finds the engine idle
      if (s_reg.st == h_idle || ans.done) begin
        s_next.st = h_idle;
      end else begin
        s_next.st = h_rst;
      end
    end else begin
      unique case (s_reg.st)
        h_idle: begin
          if (reg_write && reg_addr == flash_status_pkg::ctrl_off) begin
            s_next.done = 1'b0;
            s_next.fail = 1'b0;
            if (reg_wdata[flash_status_pkg::go_toggle_pos]) begin
              s_next.st = h_rd1;
              s_next.req = rd_req(s_reg.addr);
            end else if (reg_wdata[flash_status_pkg::go_poll_pos]) begin
              s_next.st = h_poll;
              s_next.req = rd_req(s_reg.addr);
            end else if (reg_wdata[flash_status_pkg::go_read_pos]) begin
              s_next.st = h_one;
              s_next.req = rd_req(s_reg.addr);
            end else if (reg_wdata[flash_status_pkg::go_write_pos]) begin
              s_next.st = h_one;
              s_next.req = '{go: 1'b1, write: 1'b1, addr: s_reg.addr, data: s_reg.wdata};
            end
          end
        end
        h_rd1: begin
          if (ans.done) begin
            s_next.first = ans.data;
            s_next.last = ans.data;
            s_next.st = h_rd2;
            s_next.req = rd_req(s_reg.addr);
          end
        end
        h_rd2: begin
          // Two reads in a row decide whether the toggle bit moves
          if (ans.done) begin
            s_next.last = ans.data;
            if (!toggling(s_reg.first, ans.data)) begin
              s_next.done = 1'b1;
              s_next.st = h_idle;
            end else if (ans.data[flash_status_pkg::timeout_flag_pos]) begin
              s_next.st = h_rd3;
              s_next.req = rd_req(s_reg.addr);
            end else begin
              s_next.first = ans.data;
              s_next.req = rd_req(s_reg.addr);
            end
          end
        end
        h_rd3: begin
          if (ans.done) begin
            s_next.first = ans.data;
            s_next.st = h_rd4;
            s_next.req = rd_req(s_reg.addr);
          end
        end
        h_rd4: begin
          // Toggle may stop just as the timeout flag rises
          if (ans.done) begin
            s_next.last = ans.data;
            if (!toggling(s_reg.first, ans.data)) begin
              s_next.done = 1'b1;
              s_next.st = h_idle;
            end else begin
              s_next.fail = 1'b1;
              s_next.st = h_rst;
              s_next.req = '{go: 1'b1, write: 1'b1, addr: s_reg.addr,
                             data: flash_status_pkg::reset_cmd};
            end
          end
        end
        h_poll: begin
          if (ans.done) begin
            s_next.last = ans.data;
            if (ans.data[flash_status_pkg::polling_bit_pos] ==
                s_reg.expect_data[flash_status_pkg::polling_bit_pos]) begin
              // Full byte is only trusted on the next read
              s_next.st = h_one;
              s_next.done = 1'b1;
              s_next.req = rd_req(s_reg.addr);
            end else if (ans.data[flash_status_pkg::timeout_flag_pos]) begin
              // Timeout seen: one more poll read, then judge
              s_next.st = h_rd4;
              s_next.first = ans.data;
              s_next.req = rd_req(s_reg.addr);
            end else begin
              s_next.req = rd_req(s_reg.addr);
            end
          end
        end
        h_rst: begin
          // Reset command or an aborted cycle finishes here
          if (ans.done) begin
            s_next.st = h_idle;
          end
        end
        h_one: begin
          if (ans.done) begin
            s_next.last = ans.data;
            s_next.st = h_idle;
          end
        end
        default: s_next.st = h_idle;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s_reg <= '0;
      s_reg.st <= h_idle;
      s_reg.addr <= flash_status_pkg::addr_reset;
      s_reg.rb_s1 <= 1'b1;
      s_reg.rb_s2 <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // Pins straight from the cycle engine flops
  assign reg_rdata = s_reg.rdata;
  assign flash_addr = pins.addr;
  assign flash_dq_out = pins.dq_out;
  assign flash_dq_oe = pins.dq_oe;
  assign chip_select_n = pins.chip_select_n;
  assign output_strobe_n = pins.output_strobe_n;
  assign write_strobe_n = pins.write_strobe_n;

endmodule : flash_status_host

// ==== tb/flash_status_host_properties.sv ====
module flash_status_host_properties (
  input wire logic ref_clk, // Clock
  input wire logic reset, // Async reset
  input wire logic reg_read, // Register read strobe
  input wire logic [31:0] reg_rdata, // Register read data
  input wire logic [20:0] flash_addr, // Flash address
  input wire logic flash_dq_oe, // Data drive enable
  input wire logic chip_select_n, // Chip select
  input wire logic output_strobe_n, // Read strobe
  input wire logic write_strobe_n // Write strobe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////////
  // Bus cycle shape seen by the flash
  a_strobe_excl: assert property (!output_strobe_n |-> write_strobe_n)
    else $error("read and write strobes low together");
  a_read_cs: assert property (!output_strobe_n |-> !chip_select_n && !flash_dq_oe)
    else $error("read strobe without select or with bus driven");
  a_read_len: assert property ($fell(output_strobe_n) |-> !output_strobe_n [*7] ##1 output_strobe_n)
    else $error("read strobe length wrong");
  a_read_gap: assert property ($rose(output_strobe_n) |-> output_strobe_n [*4])
    else $error("read cycles too close");
  a_addr_hold: assert property (!output_strobe_n && !$past(output_strobe_n) |-> $stable(flash_addr))
    else $error("address moved inside read");
  a_write_len: assert property ($fell(write_strobe_n) |-> !write_strobe_n [*5] ##1 write_strobe_n)
    else $error("write strobe length wrong");
  a_write_hold: assert property ($rose(write_strobe_n) |-> flash_dq_oe [*3])
    else $error("write data released early");
  a_write_drive: assert property (!write_strobe_n |-> flash_dq_oe && !chip_select_n)
    else $error("write strobe without data or select");
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  // Main traffic seen at least once
  c_read: cover property ($fell(output_strobe_n));
  c_write: cover property ($fell(write_strobe_n));
  c_reg_read: cover property (reg_read ##1 reg_rdata != 32'h0);
endmodule : flash_status_host_properties

bind flash_status_host flash_status_host_properties u_flash_status_host_properties (
  .ref_clk(ref_clk), .reset(reset), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .flash_addr(flash_addr), .flash_dq_oe(flash_dq_oe), .chip_select_n(chip_select_n),
  .output_strobe_n(output_strobe_n), .write_strobe_n(write_strobe_n));

// ==== tb/flash_model.sv ====
module flash_model (
  input wire logic chip_select_n, // Chip select, active low
  input wire logic output_strobe_n, // Read strobe, active low
  input wire logic write_strobe_n, // Write strobe, active low
  input wire logic [20:0] addr, // Address from host
  input wire logic [7:0] dq_from_host, // Data driven by host
  output logic [7:0] dq, // Data toward host
  output logic pull_low // Pulls ready line low
);
  timeunit 1ns;
  timeprecision 100ps;
  // Kinds: 0 array, 1 program, 2 erase, 3 erase suspended
  logic [1:0] kind = 2'h0;
  logic [7:0] target = 8'h00;
  logic [7:0] last_wr = 8'h00;
  logic [20:0] rd_addr = 21'h000000;
  logic tmo = 1'b0;
  logic tog = 1'b0;
  logic rd_open = 1'b0;
  logic wr_open = 1'b0;
  int left = 0;
  int reads = 0;
  int writes = 0;
  initial dq = 8'h00;
  ////////////////////////////////////////////////////////////////////////////////
  // Loaded as if the final command write just rose
  task automatic begin_op(input logic [1:0] k, input logic [7:0] t, input int n, input logic f);
    kind = k;
    target = t;
    left = n;
    tmo = f;
  endtask : begin_op
  // Status byte; the polling bit turns true one read before the low bits
  function automatic logic [7:0] status_byte();
    logic [7:0] s;
    s = 8'h00;
    s[7] = (kind == 2'h1) ? ~target[7] : (kind == 2'h3);
    if (left == 1) s[7] = target[7];
    s[6] = (kind == 2'h3) ? 1'b0 : tog;
    s[5] = tmo;
    s[3] = (kind == 2'h2);
    s[2] = kind[1] & tog;
    return s;
  endfunction : status_byte
  // Read opens: status or array byte
  always @(negedge output_strobe_n) begin
    // Select and address change in the same step as the strobe; let them settle
    #1;
    if (!chip_select_n) begin
      rd_open = 1'b1;
      rd_addr = addr;
      dq = (kind == 2'h0) ? target : status_byte();
    end
  end
  // Read closes: advance toggles, count down, leave bus inverted so stale data never matches
  always @(posedge output_strobe_n) begin
    if (rd_open) begin
      rd_open = 1'b0;
      reads = reads + 1;
      if (kind != 2'h0) tog = ~tog;
      if (kind != 2'h3 && left > 0) left = left - 1;
      if (kind != 2'h3 && left == 0) kind = 2'h0;
      dq = ~dq;
    end
  end
  // Writes: reset command returns to array reads
  always @(negedge write_strobe_n) begin
    #1;
    wr_open = !chip_select_n;
  end
  always @(posedge write_strobe_n) begin
    if (wr_open) begin
      wr_open = 1'b0;
      writes = writes + 1;
      last_wr = dq_from_host;
      if (dq_from_host == flash_status_pkg::reset_cmd) begin
        kind = 2'h0;
        tmo = 1'b0;
        left = 0;
      end
    end
  end
  // Open drain: low only while programming or erasing
  assign pull_low = (kind == 2'h1) || (kind == 2'h2);
endmodule : flash_model

// ==== tb/tb_top.sv ====
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata, rd;
  logic [20:0] flash_addr;
  logic [7:0] flash_dq_out, model_dq;
  logic flash_dq_oe, chip_select_n, output_strobe_n, write_strobe_n, pull_low;
  int error_cnt = 0;
  int num_checks = 0;
  int cycles = 0;
  int r0;
  // Shared data wire; pull-up on the ready line
  wire logic [7:0] flash_dq_in = flash_dq_oe ? flash_dq_out : model_dq;
  wire logic ready_busy_n = pull_low ? 1'b0 : 1'b1;
  flash_status_host u_flash_status_host (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .flash_addr(flash_addr), .flash_dq_in(flash_dq_in), .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe), .chip_select_n(chip_select_n), .output_strobe_n(output_strobe_n),
    .write_strobe_n(write_strobe_n), .ready_busy_n(ready_busy_n));
  flash_model u_flash_model (.chip_select_n(chip_select_n), .output_strobe_n(output_strobe_n),
    .write_strobe_n(write_strobe_n), .addr(flash_addr), .dq_from_host(flash_dq_out),
    .dq(model_dq), .pull_low(pull_low));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask : reg_wr
  // Data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_rd
  // Bounded wait on the busy bit
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (3) @(posedge ref_clk);
    reg_rd(flash_status_pkg::stat_off, rd);
    while (rd[0] !== 1'b0 && n < 3000) begin
      reg_rd(flash_status_pkg::stat_off, rd);
      n++;
    end
    chk("busy", 32'h0, {31'h0, rd[0]});
  endtask : wait_idle
  task automatic run_op(input int pos);
    reg_wr(flash_status_pkg::ctrl_off, 32'h1 << pos);
    wait_idle();
  endtask : run_op
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    reg_rd(flash_status_pkg::stat_off, rd);
    chk("status after reset", 32'h8, rd);
    reg_rd(4'h7, rd);
    chk("unmapped", 32'h0, rd);
  endtask : t_reset
  // Program or erase poll: ready low while busy, extra read after polling bit flips
  task automatic t_poll(input logic [1:0] k, input logic [7:0] t, input int n);
    reg_wr(flash_status_pkg::addr_off, 32'h00001234);
    reg_wr(flash_status_pkg::data_off, {16'h0, t, t});
    u_flash_model.begin_op(k, t, n, 1'b0);
    r0 = u_flash_model.reads;
    reg_wr(flash_status_pkg::ctrl_off, 32'h1 << flash_status_pkg::go_poll_pos);
    repeat (6) @(posedge ref_clk);
    reg_rd(flash_status_pkg::stat_off, rd);
    chk("ready while busy", 32'h0, {31'h0, rd[3]});
    wait_idle();
    chk("poll reads", n + 1, u_flash_model.reads - r0);
    chk("poll address", 32'h00001234, {11'h0, u_flash_model.rd_addr});
    reg_rd(flash_status_pkg::stat_off, rd);
    chk("poll status", 32'h0000000a, rd & 32'hf);
    reg_rd(flash_status_pkg::last_off, rd);
    chk("poll byte", {24'h0, t}, rd);
  endtask : t_poll
  task automatic t_toggle_ok();
    u_flash_model.begin_op(2'h2, 8'h3c, 3, 1'b0);
    r0 = u_flash_model.writes;
    run_op(flash_status_pkg::go_toggle_pos);
    reg_rd(flash_status_pkg::stat_off, rd);
    chk("toggle ok", 32'h2, rd & 32'h7);
    chk("no reset cmd", r0, u_flash_model.writes);
    reg_rd(flash_status_pkg::last_off, rd);
    chk("toggle byte", 32'h3c, rd);
  endtask : t_toggle_ok
  // Toggling never stops with timeout flag up: reset command expected
  task automatic t_toggle_fail();
    u_flash_model.begin_op(2'h1, 8'h00, 1000, 1'b1);
    run_op(flash_status_pkg::go_toggle_pos);
    reg_rd(flash_status_pkg::stat_off, rd);
    chk("toggle fail", 32'h4, rd & 32'h7);
    chk("reset cmd", {24'h0, flash_status_pkg::reset_cmd}, {24'h0, u_flash_model.last_wr});
  endtask : t_toggle_fail
  // Abort mid-check, then a restart must begin with a fresh pair of reads
  task automatic t_abort();
    u_flash_model.begin_op(2'h1, 8'h11, 1000, 1'b0);
    reg_wr(flash_status_pkg::ctrl_off, 32'h1 << flash_status_pkg::go_toggle_pos);
    repeat (100) @(posedge ref_clk);
    run_op(flash_status_pkg::abort_pos);
    u_flash_model.begin_op(2'h0, 8'h22, 0, 1'b0);
    r0 = u_flash_model.reads;
    run_op(flash_status_pkg::go_toggle_pos);
    chk("restart reads", 32'h2, u_flash_model.reads - r0);
    reg_rd(flash_status_pkg::stat_off, rd);
    chk("restart status", 32'h2, rd & 32'h6);
  endtask : t_abort
  task automatic t_single();
    u_flash_model.begin_op(2'h0, 8'hc3, 0, 1'b0);
    reg_wr(flash_status_pkg::addr_off, 32'h00000777);
    run_op(flash_status_pkg::go_read_pos);
    reg_rd(flash_status_pkg::last_off, rd);
    chk("single read", 32'hc3, rd);
    reg_wr(flash_status_pkg::data_off, 32'h0000005a);
    run_op(flash_status_pkg::go_write_pos);
    chk("single write", 32'h5a, {24'h0, u_flash_model.last_wr});
  endtask : t_single
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  // Hang guard, well above the several hundred cycles the run needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 60000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset();
    t_poll(2'h1, 8'h5a, 3);
    t_poll(2'h2, 8'hff, 4);
    t_toggle_ok();
    t_toggle_fail();
    t_abort();
    t_single();
    give_verdict();
  end
endmodule : tb_top
